// ---- rtl/rcb_pkg.sv ----
package rcb_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned GPIO_W   = 83;
  localparam int unsigned SRC_W    = 6;
  localparam int unsigned RATE_W   = 8;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned CLK_MHZ  = 100;

  // ----------------------------------------------------------------
  // Synchronised input bit positions
  // ----------------------------------------------------------------
  localparam int unsigned SRC_SUPPLY = 0;
  localparam int unsigned SRC_WDOG   = 1;
  localparam int unsigned SRC_STRIKE = 2;
  localparam int unsigned SRC_MLOCK  = 3;
  localparam int unsigned SRC_LLOCK  = 4;
  localparam int unsigned SRC_WAKE   = 5;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned MPLL_OFF_NS  = 500;
  localparam int unsigned RST_HOLD_NS  = 1000;
  localparam logic [CNT_W-1:0] MPLL_OFF_CYC = CNT_W'((MPLL_OFF_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] RST_HOLD_CYC = CNT_W'((RST_HOLD_NS * CLK_MHZ + 999) / 1000);

  // ----------------------------------------------------------------
  // Spread spectrum encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] SSC_OFF  = 2'h0;
  localparam logic [1:0] SSC_HALF = 2'h1;
  localparam logic [1:0] SSC_FULL = 2'h2;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [GPIO_W-1:0] GPIO_KEEP_ALT = {GPIO_W{1'b0}};
  localparam logic [RATE_W-1:0] RATE_RST      = 8'h00;

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_POR,
    ST_MLOCK,
    ST_RST,
    ST_RUN
  } rcb_main_st_t;

  typedef enum logic [2:0] {
    L_OFF,
    L_RATE,
    L_WAIT,
    L_LOCKED,
    L_RATESET,
    L_RUN
  } rcb_link_st_t;

endpackage

// ---- rtl/rcb_sync.sv ----
`timescale 1ns/1ns
module rcb_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } rcb_sync_st_t;

  rcb_sync_st_t st_ff;
  rcb_sync_st_t nxt_st;

  always_comb
  begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_i;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    // Accept a change once stages two and three agree
    for (int i = 0; i < W; i++)
    begin
      if (st_ff.s2[i] == st_ff.s3[i])
      begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign q_o = st_ff.q;

endmodule // rcb_sync

// ---- rtl/rcb_top.sv ----
// Behaviour
// - Power-up starts master PLL, normal mode, reset.
// - Any reset source returns normal power mode.
// - All general pins high impedance around reset.
// - Master PLL stays on except power-up.
// - Only processor resets released; others wait software.
// - Processor clocks at full rate after reset.
// - Front-end clocks disabled until software enables.
// - Link PLL down, clocks off, resets held.
// - Link I/O powered down, outputs high impedance.
// - External resets held until processor releases them.
// - Processor boots from external flash after reset.
// - Link bring-up follows fixed firmware order.
// - Wake request lets software restore normal mode.
// - Link spread spectrum off, 0.5%, 1.0%.
// - 83 pins, direction, open-drain, alternate functions.
// - Pins reset to input; all alternates reset.
`timescale 1ns/1ns
module rcb_top (
  input  wire logic                       clk_i,
  input  wire logic                       sys_rst_i,
  input  wire logic                       supply_good_reset_i,
  input  wire logic                       wdog_rst_i,
  input  wire logic                       strike_rst_i,
  input  wire logic                       mpll_lock_i,
  input  wire logic                       link_pll_lock_i,
  input  wire logic                       wake_i,
  input  wire logic                       sw_int_rst_release_i,
  input  wire logic                       sw_ext_rst_release_i,
  input  wire logic                       sw_fe_clk_en_i,
  input  wire logic                       sw_cpu_slow_i,
  input  wire logic                       sw_low_power_i,
  input  wire logic                       sw_wake_ack_i,
  input  wire logic                       sw_link_rate_wr_i,
  input  wire logic [rcb_pkg::RATE_W-1:0] sw_link_rate_i,
  input  wire logic                       sw_link_pll_en_i,
  input  wire logic                       sw_link_div_release_i,
  input  wire logic                       sw_link_io_en_i,
  input  wire logic [1:0]                 sw_ssc_mode_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] sw_gpio_dir_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] sw_gpio_od_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] sw_gpio_dout_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] sw_gpio_alt_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] alt_out_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] alt_oe_i,
  input  wire logic [rcb_pkg::GPIO_W-1:0] gpio_in_i,
  output logic                            mpll_en_o,
  output logic                            normal_mode_o,
  output logic                            cpu_rst_n_o,
  output logic                            int_rst_n_o,
  output logic                            ext_rst_n_o,
  output logic                            cpu_clk_full_o,
  output logic                            boot_flash_o,
  output logic                            fe_clk_en_o,
  output logic                            link_pll_en_o,
  output logic [rcb_pkg::RATE_W-1:0]      link_pll_rate_o,
  output logic [rcb_pkg::RATE_W-1:0]      link_div_rate_o,
  output logic                            link_div_rst_o,
  output logic                            link_clk_en_o,
  output logic                            link_io_pd_o,
  output logic                            link_io_oe_o,
  output logic [1:0]                      ssc_mode_o,
  output logic                            wake_pend_o,
  output logic [rcb_pkg::GPIO_W-1:0]      gpio_in_o,
  output logic [rcb_pkg::GPIO_W-1:0]      gpio_out_o,
  output logic [rcb_pkg::GPIO_W-1:0]      gpio_oe_o,
  output logic [rcb_pkg::GPIO_W-1:0]      gpio_alt_rst_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [rcb_pkg::SRC_W-1:0]  src_sync;
  logic [rcb_pkg::GPIO_W-1:0] gpio_sync;
  logic                       any_src;

  rcb_sync #(
    .W (rcb_pkg::SRC_W)
  ) u_src_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       ({wake_i, link_pll_lock_i, mpll_lock_i, strike_rst_i, wdog_rst_i, supply_good_reset_i}),
    .q_o       (src_sync)
  );

  rcb_sync #(
    .W (rcb_pkg::GPIO_W)
  ) u_gpio_sync (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .d_i       (gpio_in_i),
    .q_o       (gpio_sync)
  );

  // Merged warm reset sources
  assign any_src = src_sync[rcb_pkg::SRC_SUPPLY] | src_sync[rcb_pkg::SRC_WDOG] |
                   src_sync[rcb_pkg::SRC_STRIKE];

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    rcb_pkg::rcb_main_st_t      st;
    rcb_pkg::rcb_link_st_t      lst;
    logic [rcb_pkg::CNT_W-1:0]  cnt;
    logic                       mpll_en;
    logic                       normal;
    logic                       cpu_rst_n;
    logic                       int_rst_n;
    logic                       ext_rst_n;
    logic                       cpu_full;
    logic                       boot_flash;
    logic                       fe_clk_en;
    logic                       link_pll_en;
    logic [rcb_pkg::RATE_W-1:0] pll_rate;
    logic [rcb_pkg::RATE_W-1:0] div_rate;
    logic                       link_div_rst;
    logic                       link_clk_en;
    logic                       link_io_pd;
    logic                       link_io_oe;
    logic [1:0]                 ssc;
    logic                       wake_pend;
    logic [rcb_pkg::GPIO_W-1:0] gin;
    logic [rcb_pkg::GPIO_W-1:0] gout;
    logic [rcb_pkg::GPIO_W-1:0] goe;
    logic [rcb_pkg::GPIO_W-1:0] alt_rst;
  } rcb_top_st_t;

  rcb_top_st_t st_ff;
  rcb_top_st_t nxt_st;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st     = st_ff;
    nxt_st.gin = gpio_sync;

    case (st_ff.st)
      // Master PLL held off briefly, then started
      rcb_pkg::ST_POR:
      begin
        nxt_st.mpll_en = 1'b0;
        nxt_st.normal  = 1'b1;
        if (st_ff.cnt >= rcb_pkg::MPLL_OFF_CYC - 1'b1)
        begin
          nxt_st.cnt     = '0;
          nxt_st.mpll_en = 1'b1;
          nxt_st.st      = rcb_pkg::ST_MLOCK;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      rcb_pkg::ST_MLOCK:
      begin
        if (src_sync[rcb_pkg::SRC_MLOCK])
        begin
          nxt_st.cnt = '0;
          nxt_st.st  = rcb_pkg::ST_RST;
        end
      end
      rcb_pkg::ST_RST:
      begin
        if (any_src)
        begin
          nxt_st.cnt = '0;
        end
        else if (st_ff.cnt >= rcb_pkg::RST_HOLD_CYC - 1'b1)
        begin
          nxt_st.cpu_rst_n = 1'b1;
          nxt_st.st        = rcb_pkg::ST_RUN;
        end
        else
        begin
          nxt_st.cnt = st_ff.cnt + 1'b1;
        end
      end
      rcb_pkg::ST_RUN:
      begin
        if (sw_int_rst_release_i)
        begin
          nxt_st.int_rst_n = 1'b1;
        end
        nxt_st.cpu_full  = ~sw_cpu_slow_i;
        nxt_st.fe_clk_en = sw_fe_clk_en_i;
        nxt_st.normal    = ~sw_low_power_i;
        nxt_st.ssc       = (sw_ssc_mode_i == rcb_pkg::SSC_HALF ||
                            sw_ssc_mode_i == rcb_pkg::SSC_FULL) ? sw_ssc_mode_i : rcb_pkg::SSC_OFF;

        // Link clock generator bring-up
        case (st_ff.lst)
          rcb_pkg::L_OFF:
          begin
            if (sw_link_rate_wr_i)
            begin
              nxt_st.pll_rate = sw_link_rate_i;
              nxt_st.lst      = rcb_pkg::L_RATE;
            end
          end
          rcb_pkg::L_RATE:
          begin
            if (sw_link_pll_en_i)
            begin
              nxt_st.link_pll_en  = 1'b1;
              nxt_st.link_div_rst = 1'b1;
              nxt_st.lst          = rcb_pkg::L_WAIT;
            end
          end
          rcb_pkg::L_WAIT:
          begin
            if (src_sync[rcb_pkg::SRC_LLOCK])
            begin
              nxt_st.lst = rcb_pkg::L_LOCKED;
            end
          end
          rcb_pkg::L_LOCKED:
          begin
            if (sw_link_rate_wr_i)
            begin
              nxt_st.div_rate = sw_link_rate_i;
              nxt_st.lst      = rcb_pkg::L_RATESET;
            end
          end
          rcb_pkg::L_RATESET:
          begin
            if (sw_link_div_release_i)
            begin
              nxt_st.link_div_rst = 1'b0;
              nxt_st.link_clk_en  = 1'b1;
              nxt_st.lst          = rcb_pkg::L_RUN;
            end
          end
          rcb_pkg::L_RUN:
          begin
            if (sw_ext_rst_release_i)
            begin
              nxt_st.ext_rst_n = 1'b1;
            end
            nxt_st.link_io_pd = ~sw_link_io_en_i;
            nxt_st.link_io_oe = sw_link_io_en_i;
          end
          default:
          begin
            nxt_st.lst = rcb_pkg::L_OFF;
          end
        endcase

        // Pin configuration
        for (int i = 0; i < rcb_pkg::GPIO_W; i++)
        begin
          if (sw_gpio_alt_i[i])
          begin
            nxt_st.gout[i] = alt_out_i[i];
            nxt_st.goe[i]  = alt_oe_i[i];
          end
          else if (sw_gpio_od_i[i])
          begin
            nxt_st.gout[i] = 1'b0;
            nxt_st.goe[i]  = sw_gpio_dir_i[i] & ~sw_gpio_dout_i[i];
          end
          else
          begin
            nxt_st.gout[i] = sw_gpio_dout_i[i];
            nxt_st.goe[i]  = sw_gpio_dir_i[i];
          end
        end
        nxt_st.alt_rst = '0;

        if (any_src)
        begin
          nxt_st.cnt = '0;
          nxt_st.st  = rcb_pkg::ST_RST;
        end
      end
      default:
      begin
        nxt_st.st = rcb_pkg::ST_POR;
      end
    endcase

    // Defaults imposed while any reset is in progress
    if (st_ff.st != rcb_pkg::ST_RUN || (st_ff.st == rcb_pkg::ST_RUN && any_src))
    begin
      nxt_st.normal       = 1'b1;
      nxt_st.int_rst_n    = 1'b0;
      nxt_st.ext_rst_n    = 1'b0;
      nxt_st.cpu_full     = 1'b1;
      nxt_st.boot_flash   = 1'b1;
      nxt_st.fe_clk_en    = 1'b0;
      nxt_st.lst          = rcb_pkg::L_OFF;
      nxt_st.link_pll_en  = 1'b0;
      nxt_st.link_div_rst = 1'b1;
      nxt_st.link_clk_en  = 1'b0;
      nxt_st.link_io_pd   = 1'b1;
      nxt_st.link_io_oe   = 1'b0;
      nxt_st.ssc          = rcb_pkg::SSC_OFF;
      nxt_st.gout         = '0;
      nxt_st.goe          = '0;
      nxt_st.alt_rst      = ~rcb_pkg::GPIO_KEEP_ALT;
      if (st_ff.st != rcb_pkg::ST_RUN)
      begin
        nxt_st.cpu_rst_n = (nxt_st.st == rcb_pkg::ST_RUN);
      end
      else
      begin
        nxt_st.cpu_rst_n = 1'b0;
      end
      if (st_ff.st == rcb_pkg::ST_RUN || st_ff.st == rcb_pkg::ST_RST)
      begin
        nxt_st.mpll_en = 1'b1;
      end
    end

    // Sticky wake flag, set beats clear
    if (src_sync[rcb_pkg::SRC_WAKE])
    begin
      nxt_st.wake_pend = 1'b1;
    end
    else if (sw_wake_ack_i)
    begin
      nxt_st.wake_pend = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      st_ff              <= '0;
      st_ff.st           <= rcb_pkg::ST_POR;
      st_ff.lst          <= rcb_pkg::L_OFF;
      st_ff.normal       <= 1'b1;
      st_ff.cpu_full     <= 1'b1;
      st_ff.boot_flash   <= 1'b1;
      st_ff.pll_rate     <= rcb_pkg::RATE_RST;
      st_ff.div_rate     <= rcb_pkg::RATE_RST;
      st_ff.link_div_rst <= 1'b1;
      st_ff.link_io_pd   <= 1'b1;
      st_ff.ssc          <= rcb_pkg::SSC_OFF;
      st_ff.alt_rst      <= ~rcb_pkg::GPIO_KEEP_ALT;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign mpll_en_o       = st_ff.mpll_en;
  assign normal_mode_o   = st_ff.normal;
  assign cpu_rst_n_o     = st_ff.cpu_rst_n;
  assign int_rst_n_o     = st_ff.int_rst_n;
  assign ext_rst_n_o     = st_ff.ext_rst_n;
  assign cpu_clk_full_o  = st_ff.cpu_full;
  assign boot_flash_o    = st_ff.boot_flash;
  assign fe_clk_en_o     = st_ff.fe_clk_en;
  assign link_pll_en_o   = st_ff.link_pll_en;
  assign link_pll_rate_o = st_ff.pll_rate;
  assign link_div_rate_o = st_ff.div_rate;
  assign link_div_rst_o  = st_ff.link_div_rst;
  assign link_clk_en_o   = st_ff.link_clk_en;
  assign link_io_pd_o    = st_ff.link_io_pd;
  assign link_io_oe_o    = st_ff.link_io_oe;
  assign ssc_mode_o      = st_ff.ssc;
  assign wake_pend_o     = st_ff.wake_pend;
  assign gpio_in_o       = st_ff.gin;
  assign gpio_out_o      = st_ff.gout;
  assign gpio_oe_o       = st_ff.goe;
  assign gpio_alt_rst_o  = st_ff.alt_rst;

endmodule // rcb_top

// ---- dv/rcb_top_assertions.sv ----
`timescale 1ns/1ns
module rcb_top_assertions (
  input wire logic                       clk_i,
  input wire logic                       sys_rst_i,
  input wire logic                       supply_good_reset_i,
  input wire logic                       wdog_rst_i,
  input wire logic                       strike_rst_i,
  input wire logic                       mpll_en_o,
  input wire logic                       normal_mode_o,
  input wire logic                       cpu_rst_n_o,
  input wire logic                       int_rst_n_o,
  input wire logic                       ext_rst_n_o,
  input wire logic                       cpu_clk_full_o,
  input wire logic                       boot_flash_o,
  input wire logic                       fe_clk_en_o,
  input wire logic                       link_pll_en_o,
  input wire logic                       link_div_rst_o,
  input wire logic                       link_clk_en_o,
  input wire logic                       link_io_pd_o,
  input wire logic                       link_io_oe_o,
  input wire logic [1:0]                 ssc_mode_o,
  input wire logic                       wake_pend_o,
  input wire logic [rcb_pkg::GPIO_W-1:0] gpio_oe_o,
  input wire logic [rcb_pkg::GPIO_W-1:0] gpio_alt_rst_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  // ----------------------------------------
  // Reset entry and defaults
  // ----------------------------------------
  a_por_defaults: assert property (
    $fell(sys_rst_i) |-> gpio_oe_o == '0 && gpio_alt_rst_o == '1 && link_io_pd_o && !link_io_oe_o
      && !cpu_rst_n_o && !int_rst_n_o && !ext_rst_n_o && normal_mode_o) else $error("reset defaults wrong");
  a_por_clocks: assert property (
    $fell(sys_rst_i) |-> cpu_clk_full_o && boot_flash_o && !fe_clk_en_o && !link_clk_en_o
      && link_div_rst_o && !link_pll_en_o) else $error("reset clock defaults wrong");
  a_por_pll_wait: assert property (
    $fell(sys_rst_i) |-> ##40 !mpll_en_o ##[1:20] mpll_en_o) else $error("master pll start wrong");
  a_warm_entry: assert property (
    (cpu_rst_n_o && (supply_good_reset_i || wdog_rst_i || strike_rst_i)) [*3] |-> ##[1:6] !cpu_rst_n_o)
    else $error("warm reset not taken");
  a_warm_defaults: assert property (
    $fell(cpu_rst_n_o) |-> normal_mode_o && mpll_en_o && !ext_rst_n_o && !int_rst_n_o && link_io_pd_o
      && !link_io_oe_o && !link_pll_en_o && gpio_oe_o == '0) else $error("warm reset defaults wrong");
  a_pll_stays_on: assert property (
    mpll_en_o |=> mpll_en_o) else $error("master pll dropped");

  // ----------------------------------------
  // Release order
  // ----------------------------------------
  a_cpu_first: assert property (
    $rose(int_rst_n_o) |-> cpu_rst_n_o && $past(cpu_rst_n_o)) else $error("internal reset before cpu");
  a_div_after_pll: assert property (
    $fell(link_div_rst_o) |-> link_pll_en_o && link_clk_en_o) else $error("divider released early");
  a_ext_after_link: assert property (
    $rose(ext_rst_n_o) |-> !link_div_rst_o && cpu_rst_n_o) else $error("external reset released early");
  a_fe_in_run: assert property (
    fe_clk_en_o |-> cpu_rst_n_o) else $error("front end clock outside run");
  a_io_in_run: assert property (
    link_io_oe_o |-> !link_io_pd_o && link_clk_en_o) else $error("link io driven early");
  a_ssc_legal: assert property (
    ssc_mode_o != 2'h3) else $error("illegal spread mode");

  c_ext_release: cover property ($rose(ext_rst_n_o));
  c_warm_reset: cover property ($fell(cpu_rst_n_o));
  c_ssc_full: cover property (ssc_mode_o == 2'h2);
  c_wake: cover property ($rose(wake_pend_o));
endmodule // rcb_top_assertions

// ---- dv/rcb_top_tb.sv ----
`timescale 1ns/1ns
module rcb_top_tb;
  logic clk_i = 1'b0;
  logic mpll_lock_i = 1'b0;
  logic sys_rst_i, supply_good_reset_i, wdog_rst_i, strike_rst_i, link_pll_lock_i, wake_i;
  logic sw_int_rst_release_i, sw_ext_rst_release_i, sw_fe_clk_en_i, sw_cpu_slow_i, sw_low_power_i;
  logic sw_wake_ack_i, sw_link_rate_wr_i, sw_link_pll_en_i, sw_link_div_release_i, sw_link_io_en_i;
  logic [rcb_pkg::RATE_W-1:0] sw_link_rate_i, link_pll_rate_o, link_div_rate_o;
  logic [1:0]                 sw_ssc_mode_i, ssc_mode_o;
  logic [rcb_pkg::GPIO_W-1:0] sw_gpio_dir_i, sw_gpio_od_i, sw_gpio_dout_i, sw_gpio_alt_i;
  logic [rcb_pkg::GPIO_W-1:0] alt_out_i, alt_oe_i, gpio_in_i, gpio_in_o, gpio_out_o, gpio_oe_o, gpio_alt_rst_o;
  logic mpll_en_o, normal_mode_o, cpu_rst_n_o, int_rst_n_o, ext_rst_n_o, cpu_clk_full_o, boot_flash_o;
  logic fe_clk_en_o, link_pll_en_o, link_div_rst_o, link_clk_en_o, link_io_pd_o, link_io_oe_o, wake_pend_o;
  localparam logic [rcb_pkg::GPIO_W-1:0] PAT = 83'h2aaaaaaaaaaaaaaaaaaaa;
  int fails = 0;
  int comparisons = 0;
  int cycles = 0;

  rcb_top uut (.*);

  // ----------------------------------------
  // Clock, master PLL stand-in, timeout
  // ----------------------------------------
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) mpll_lock_i <= mpll_en_o;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [rcb_pkg::GPIO_W-1:0] seen, input logic [rcb_pkg::GPIO_W-1:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: %s", $time, what);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic wait_cpu(input logic v, input int lim);
    int n;
    n = 0;
    while (cpu_rst_n_o !== v && n < lim)
    begin
      @(negedge clk_i);
      n++;
    end
    chk(cpu_rst_n_o, v, "cpu reset wait");
  endtask
  task end_of_test;
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_power_up;
    chk(mpll_en_o, 1'b0, "pll on in reset");
    chk(normal_mode_o, 1'b1, "not normal mode");
    chk(gpio_oe_o, '0, "gpio driven");
    chk(gpio_alt_rst_o, '1, "alternate not reset");
    chk({cpu_clk_full_o, boot_flash_o, fe_clk_en_o}, 3'b110, "cpu clock or boot");
    chk({link_pll_en_o, link_clk_en_o, link_div_rst_o}, 3'b001, "link pll state");
    chk({link_io_pd_o, link_io_oe_o}, 2'b10, "link io state");
    chk({cpu_rst_n_o, int_rst_n_o, ext_rst_n_o}, 3'b000, "resets released");
    idle(40);
    chk(mpll_en_o, 1'b0, "pll on early");
    idle(rcb_pkg::MPLL_OFF_CYC - 41);
    chk(mpll_en_o, 1'b0, "pll on one cycle early");
    idle(1);
    chk(mpll_en_o, 1'b1, "pll start late");
    wait_cpu(1'b1, 300);
    chk({mpll_en_o, int_rst_n_o, ext_rst_n_o}, 3'b100, "run entry");
    $display("test_power_up done");
  endtask

  task test_link;
    pulse(sw_link_div_release_i);
    pulse(sw_ext_rst_release_i);
    chk({link_div_rst_o, ext_rst_n_o}, 2'b10, "early strobe taken");
    sw_link_rate_i = 8'h12;
    pulse(sw_link_rate_wr_i);
    chk(link_pll_rate_o, 8'h12, "pll rate");
    pulse(sw_link_pll_en_i);
    chk({link_pll_en_o, link_div_rst_o, link_clk_en_o}, 3'b110, "pll enable");
    sw_link_rate_i = 8'h34;
    pulse(sw_link_rate_wr_i);
    chk(link_div_rate_o, rcb_pkg::RATE_RST, "rate before lock");
    link_pll_lock_i = 1'b1;
    idle(8);
    pulse(sw_link_rate_wr_i);
    chk(link_div_rate_o, 8'h34, "divider rate");
    pulse(sw_ext_rst_release_i);
    chk(ext_rst_n_o, 1'b0, "ext before dividers");
    pulse(sw_link_div_release_i);
    chk({link_div_rst_o, link_clk_en_o}, 2'b01, "divider release");
    pulse(sw_ext_rst_release_i);
    chk(ext_rst_n_o, 1'b1, "ext release");
    sw_link_io_en_i = 1'b1;
    idle(2);
    chk({link_io_pd_o, link_io_oe_o, int_rst_n_o}, 3'b010, "link io enable");
    pulse(sw_int_rst_release_i);
    chk(int_rst_n_o, 1'b1, "internal release");
    sw_fe_clk_en_i = 1'b1;
    idle(2);
    chk(fe_clk_en_o, 1'b1, "front end clock");
    $display("test_link done");
  endtask

  task test_ssc;
    logic [1:0] exp [4];
    exp = '{rcb_pkg::SSC_OFF, rcb_pkg::SSC_HALF, rcb_pkg::SSC_FULL, rcb_pkg::SSC_OFF};
    for (int i = 0; i < 4; i++)
    begin
      sw_ssc_mode_i = 2'(i);
      idle(2);
      chk(ssc_mode_o, exp[i], "spread mode");
    end
    $display("test_ssc done");
  endtask

  task test_gpio;
    sw_gpio_dir_i = '1;
    sw_gpio_dout_i = PAT;
    gpio_in_i = PAT;
    idle(6);
    chk(gpio_oe_o, '1, "push-pull enable");
    chk(gpio_out_o, PAT, "push-pull data");
    chk(gpio_in_o, PAT, "input copy");
    sw_gpio_od_i = '1;
    sw_gpio_alt_i = 83'h2;
    alt_out_i = '1;
    alt_oe_i = '1;
    idle(2);
    chk(gpio_oe_o, ~PAT | 83'h2, "open-drain enable");
    chk(gpio_out_o, 83'h2, "open-drain data");
    sw_gpio_dir_i = '0;
    sw_gpio_alt_i = '0;
    idle(2);
    chk(gpio_oe_o, '0, "inputs driven");
    $display("test_gpio done");
  endtask

  task test_wake;
    wake_i = 1'b1;
    idle(6);
    chk(wake_pend_o, 1'b1, "wake not pending");
    pulse(sw_wake_ack_i);
    chk(wake_pend_o, 1'b1, "ack beat set");
    wake_i = 1'b0;
    idle(6);
    pulse(sw_wake_ack_i);
    chk(wake_pend_o, 1'b0, "ack ignored");
    sw_low_power_i = 1'b1;
    idle(2);
    chk(normal_mode_o, 1'b0, "low power refused");
    sw_low_power_i = 1'b0;
    sw_cpu_slow_i = 1'b1;
    idle(2);
    chk({normal_mode_o, cpu_clk_full_o}, 2'b10, "normal mode or slow cpu");
    $display("test_wake done");
  endtask

  task test_warm;
    for (int s = 0; s < 3; s++)
    begin
      sw_low_power_i = 1'b1;
      sw_gpio_dir_i = '1;
      idle(3);
      {strike_rst_i, wdog_rst_i, supply_good_reset_i} = 3'(1 << s);
      wait_cpu(1'b0, 10);
      chk({normal_mode_o, mpll_en_o, cpu_clk_full_o}, 3'b111, "warm modes");
      chk({int_rst_n_o, ext_rst_n_o, fe_clk_en_o}, 3'b000, "warm resets");
      chk({link_pll_en_o, link_div_rst_o, link_io_pd_o}, 3'b011, "warm link");
      chk(gpio_oe_o, '0, "warm gpio");
      chk(gpio_alt_rst_o, ~rcb_pkg::GPIO_KEEP_ALT, "warm alternates");
      idle(6);
      {strike_rst_i, wdog_rst_i, supply_good_reset_i} = 3'b000;
      sw_low_power_i = 1'b0;
      wait_cpu(1'b1, 200);
      chk(mpll_en_o, 1'b1, "pll lost");
    end
    $display("test_warm done");
  endtask

  initial
  begin
    sys_rst_i = 1'b1;
    {supply_good_reset_i, wdog_rst_i, strike_rst_i, link_pll_lock_i, wake_i, sw_int_rst_release_i} = '0;
    {sw_ext_rst_release_i, sw_fe_clk_en_i, sw_cpu_slow_i, sw_low_power_i, sw_wake_ack_i} = '0;
    {sw_link_rate_wr_i, sw_link_pll_en_i, sw_link_div_release_i, sw_link_io_en_i, sw_ssc_mode_i} = '0;
    {sw_link_rate_i, sw_gpio_dir_i, sw_gpio_od_i, sw_gpio_dout_i, sw_gpio_alt_i} = '0;
    {alt_out_i, alt_oe_i, gpio_in_i} = '0;
    idle(10);
    sys_rst_i = 1'b0;
    test_power_up();
    test_link();
    test_ssc();
    test_gpio();
    test_wake();
    test_warm();
    end_of_test();
  end
endmodule // rcb_top_tb

bind rcb_top rcb_top_assertions u_chk (.*);
